/* File: common/flow_map.vh */
/*
 * constants for the program-flow unit: opcode groups, flag positions,
 * cycle counts, and the pc advance taken by skips.
 * assumes nothing; definitions only.
 */
`ifndef FLOW_MAP_VH
`define FLOW_MAP_VH

// operation codes presented on op_code
`define OP_NONE        5'h00
`define OP_RELATIVE_SUBROUTINE_CALL_REL   5'h01
`define OP_CALL_IND    5'h02
`define OP_CALL_ABS    5'h03
`define OP_RET_SUB     5'h04
`define OP_RET_INT     5'h05
`define OP_CMP_SKIP_EQ 5'h06
`define OP_CMP_REG     5'h07
`define OP_CMP_CARRY   5'h08
`define OP_CMP_IMM     5'h09
`define OP_SKIP_RB_CLR 5'h0A
`define OP_SKIP_RB_SET 5'h0B
`define OP_SKIP_IO_CLR 5'h0C
`define OP_SKIP_IO_SET 5'h0D
`define OP_BR_IDX_SET  5'h0E
`define OP_BR_IDX_CLR  5'h0F

// status flag bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// cycle cost of each operation
`define CYC_CALL_REL   3'h3
`define CYC_CALL_IND   3'h3
`define CYC_CALL_ABS   3'h4
`define CYC_RETURN     3'h4
`define CYC_ONE        3'h1
`define CYC_BR_TAKEN   3'h2
`define CYC_SKIP_ONE   3'h2
`define CYC_SKIP_TWO   3'h3

// pc advance for skips
`define SKIP_STEP_ONE  16'h0002
`define SKIP_STEP_TWO  16'h0003

`endif

/* File: src/cycle_counter.v */
/*
 * busy counter: holds the unit busy for one cycle fewer than the loaded count.
 * assumes load is a single-cycle pulse while not busy.
 */
`timescale 1ns/1ps
module cycle_counter (
    clock,
    sys_rst,
    load,
    count,
    busy,
    last
);
    input  wire       clock;
    input  wire       sys_rst;
    input  wire       load;
    input  wire [2:0] count;
    output wire       busy;
    output wire       last;

    reg [2:0] remain;

    always @(posedge clock) begin
        if (sys_rst) begin
            remain <= 3'h0;
        end else if (load) begin
            remain <= count - 3'h1;
        end else if (remain != 3'h0) begin
            remain <= remain - 3'h1;
        end
    end

    assign busy = (remain != 3'h0);
    assign last = (remain == 3'h1);
endmodule

/* File: src/compare_flags.v */
/*
 * subtract-only comparator: returns the flags of a - b - cin.
 * assumes combinational use; no result is stored anywhere.
 */
`timescale 1ns/1ps
module compare_flags (
    a,
    b,
    cin,
    keep_z,
    z_in,
    zero,
    negative,
    overflow,
    carry,
    half,
    equal
);
    input  wire [7:0] a;
    input  wire [7:0] b;
    input  wire       cin;
    input  wire       keep_z;
    input  wire       z_in;
    output wire       zero;
    output wire       negative;
    output wire       overflow;
    output wire       carry;
    output wire       half;
    output wire       equal;

    wire [8:0] diff;

    assign diff     = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    // with carry in, zero only stays set if it was already set
    assign zero     = (diff[7:0] == 8'h00) & (~keep_z | z_in);
    assign negative = diff[7];
    assign overflow = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
    assign carry    = (~a[7] & b[7]) | (b[7] & diff[7]) | (diff[7] & ~a[7]);
    assign half     = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
    assign equal    = (a == b);
endmodule

/* File: src/branch_call_skip_unit.v */
/*
 * program-flow unit of an 8-bit core: calls, returns, compares, skips
 * and conditional relative branches, with their cycle costs.
 * assumes decode presents one operation per op_valid pulse with its
 * operands already fetched, and that the stack and fetch path accept
 * push/pop strobes in the cycle they are given.
 */

`timescale 1ns/1ps
`include "flow_map.vh"
module branch_call_skip_unit (
    clock,
    sys_rst,
    op_valid,
    op_code,
    op_ready,
    pc_in,
    rel_offset,
    abs_target,
    z_pointer,
    flag_index,
    reg_a,
    reg_b,
    imm_value,
    bit_select,
    io_value,
    next_is_two_word,
    flags_in,
    stack_data,
    stack_push,
    stack_pop,
    push_data,
    pc_load,
    pc_out,
    flags_we,
    flags_out,
    done
);
    input  wire        clock;
    input  wire        sys_rst;
    input  wire        op_valid;
    input  wire [4:0]  op_code;
    output wire        op_ready;
    input  wire [15:0] pc_in;
    input  wire [11:0] rel_offset;
    input  wire [15:0] abs_target;
    input  wire [15:0] z_pointer;
    input  wire [2:0]  flag_index;
    input  wire [7:0]  reg_a;
    input  wire [7:0]  reg_b;
    input  wire [7:0]  imm_value;
    input  wire [2:0]  bit_select;
    input  wire [7:0]  io_value;
    input  wire        next_is_two_word;
    input  wire [7:0]  flags_in;
    input  wire [15:0] stack_data;
    output reg         stack_push;
    output reg         stack_pop;
    output reg  [15:0] push_data;
    output reg         pc_load;
    output reg  [15:0] pc_out;
    output reg         flags_we;
    output reg  [7:0]  flags_out;
    output reg         done;

    localparam ST_IDLE = 2'h0;
    localparam ST_BUSY = 2'h1;
    localparam ST_POP  = 2'h2;

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [2:0]  cost;
    reg         jump;
    reg  [15:0] target;
    reg         push;
    reg         pop;
    reg         wr_flags;
    reg  [7:0]  new_flags;
    reg         is_ret_int;
    reg         ret_int_pending;
    reg         skip_cond;
    reg         branch_cond;
    reg         cmp_op;
    reg  [7:0]  cmp_b;

    wire        start;
    wire        busy;
    wire        last;
    wire [15:0] rel_target;
    wire [15:0] skip_target;
    wire [2:0]  skip_cost;
    wire [15:0] ret_addr;
    wire        c_zero;
    wire        c_neg;
    wire        c_ovf;
    wire        c_carry;
    wire        c_half;
    wire        c_equal;

    assign op_ready    = (state == ST_IDLE) & ~busy;
    assign start       = op_valid & op_ready;
    // 12-bit signed offset is sign extended; pc wraps at 16 bits
    assign rel_target  = pc_in + {{4{rel_offset[11]}}, rel_offset} + 16'h0001;
    assign skip_target = pc_in + (next_is_two_word ? `SKIP_STEP_TWO : `SKIP_STEP_ONE);
    assign skip_cost   = next_is_two_word ? `CYC_SKIP_TWO : `CYC_SKIP_ONE;
    // absolute call is two words long, so its return lands one further
    assign ret_addr    = pc_in + ((op_code == `OP_CALL_ABS) ? 16'h0002 : 16'h0001);

    compare_flags u_cmp (
        .a        (reg_a),
        .b        (cmp_b),
        .cin      ((op_code == `OP_CMP_CARRY) & flags_in[`FLAG_C]),
        .keep_z   (op_code == `OP_CMP_CARRY),
        .z_in     (flags_in[`FLAG_Z]),
        .zero     (c_zero),
        .negative (c_neg),
        .overflow (c_ovf),
        .carry    (c_carry),
        .half     (c_half),
        .equal    (c_equal)
    );

    // one counter serves every multi-cycle op, since ops never overlap
    cycle_counter u_cnt (
        .clock   (clock),
        .sys_rst (sys_rst),
        .load    (start),
        .count   (cost),
        .busy    (busy),
        .last    (last)
    );

    // branch family: indexed flag, and all named conditions map onto it
    always @* begin
        branch_cond = flags_in[flag_index];
        if (flag_index == `FLAG_S) begin
            // signed compare uses N xor V rather than a stored sign bit
            branch_cond = flags_in[`FLAG_N] ^ flags_in[`FLAG_V];
        end
    end

    always @* begin
        cost       = `CYC_ONE;
        jump       = 1'b0;
        target     = pc_in;
        push       = 1'b0;
        pop        = 1'b0;
        wr_flags   = 1'b0;
        new_flags  = flags_in;
        is_ret_int = 1'b0;
        skip_cond  = 1'b0;
        cmp_op     = 1'b0;
        cmp_b      = (op_code == `OP_CMP_IMM) ? imm_value : reg_b;
        case (op_code)
            `OP_RELATIVE_SUBROUTINE_CALL_REL: begin
                cost   = `CYC_CALL_REL;
                jump   = 1'b1;
                target = rel_target;
                push   = 1'b1;
            end
            `OP_CALL_IND: begin
                cost   = `CYC_CALL_IND;
                jump   = 1'b1;
                target = z_pointer;
                push   = 1'b1;
            end
            `OP_CALL_ABS: begin
                cost   = `CYC_CALL_ABS;
                jump   = 1'b1;
                target = abs_target;
                push   = 1'b1;
            end
            `OP_RET_SUB: begin
                cost = `CYC_RETURN;
                pop  = 1'b1;
            end
            `OP_RET_INT: begin
                cost       = `CYC_RETURN;
                pop        = 1'b1;
                is_ret_int = 1'b1;
            end
            `OP_CMP_SKIP_EQ: skip_cond = c_equal;
            `OP_CMP_REG, `OP_CMP_CARRY, `OP_CMP_IMM: cmp_op = 1'b1;
            `OP_SKIP_RB_CLR: skip_cond = ~reg_a[bit_select];
            `OP_SKIP_RB_SET: skip_cond = reg_a[bit_select];
            `OP_SKIP_IO_CLR: skip_cond = ~io_value[bit_select];
            `OP_SKIP_IO_SET: skip_cond = io_value[bit_select];
            `OP_BR_IDX_SET: begin
                if (branch_cond) begin
                    cost   = `CYC_BR_TAKEN;
                    jump   = 1'b1;
                    target = rel_target;
                end
            end
            `OP_BR_IDX_CLR: begin
                if (~branch_cond) begin
                    cost   = `CYC_BR_TAKEN;
                    jump   = 1'b1;
                    target = rel_target;
                end
            end
            default: begin
                cost = `CYC_ONE;
            end
        endcase
        // skips leave wr_flags low, so no flag moves
        if (skip_cond) begin
            cost   = skip_cost;
            jump   = 1'b1;
            target = skip_target;
        end
        if (cmp_op) begin
            // result is discarded, only flags are written
            wr_flags            = 1'b1;
            new_flags[`FLAG_Z]  = c_zero;
            new_flags[`FLAG_N]  = c_neg;
            new_flags[`FLAG_V]  = c_ovf;
            new_flags[`FLAG_C]  = c_carry;
            new_flags[`FLAG_H]  = c_half;
            new_flags[`FLAG_S]  = c_neg ^ c_ovf;
        end
    end

    // a one-cycle op never leaves idle
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start && cost != `CYC_ONE) begin
                    next_state = pop ? ST_POP : ST_BUSY;
                end
            end
            ST_BUSY, ST_POP: begin
                if (last) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // strobes default low so each lasts exactly one cycle
    always @(posedge clock) begin
        if (sys_rst) begin
            state           <= ST_IDLE;
            stack_push      <= 1'b0;
            stack_pop       <= 1'b0;
            push_data       <= 16'h0000;
            pc_load         <= 1'b0;
            pc_out          <= 16'h0000;
            flags_we        <= 1'b0;
            flags_out       <= 8'h00;
            done            <= 1'b0;
            ret_int_pending <= 1'b0;
        end else begin
            state      <= next_state;
            stack_push <= 1'b0;
            stack_pop  <= 1'b0;
            pc_load    <= 1'b0;
            flags_we   <= 1'b0;
            done       <= 1'b0;
            if (start) begin
                stack_push <= push;
                // return address is the word after the call itself
                push_data  <= ret_addr;
                stack_pop  <= pop;
                ret_int_pending <= is_ret_int;
                pc_load    <= jump;
                pc_out     <= target;
                flags_we   <= wr_flags;
                flags_out  <= new_flags;
                done       <= (cost == `CYC_ONE);
            end
            if (state == ST_POP && last) begin
                // stack word sampled on the final cycle of a return
                pc_load   <= 1'b1;
                pc_out    <= stack_data;
                if (ret_int_pending) begin
                    flags_we  <= 1'b1;
                    flags_out <= flags_in | (8'h01 << `FLAG_I);
                end
            end
            if (state != ST_IDLE && last) begin
                done <= 1'b1;
            end
        end
    end
endmodule

/* File: bench/flow_stack_model.sv */
/* return-address stack on the far side of the program-flow unit.
   assumes push and pop are one-cycle strobes on the core clock. */
`timescale 1ns/1ps
module flow_stack_model (
    input  logic        clock, sys_rst, stack_push, stack_pop, done,
    input  logic [15:0] push_data,
    output logic [15:0] stack_data
);
    logic [15:0] mem [0:7];
    logic [2:0]  sp;
    initial stack_data = 16'h0000;
    always @(posedge clock) begin
        if (sys_rst) begin
            sp <= 3'h0;
        end else if (stack_push) begin
            mem[sp] <= push_data;
            sp <= sp + 3'h1;
        end else if (stack_pop) begin
            stack_data <= mem[sp - 3'h1];
            sp <= sp - 3'h1;
        end else if (done) begin
            // word not held past the op end, so a late sample sees garbage
            stack_data <= ~stack_data;
        end
    end
endmodule

/* File: bench/branch_call_skip_unit_assertions.sv */
/* timing checker for the program-flow unit.
   assumes binding to the unit's ports, one clock, sync reset. */
`timescale 1ns/1ps
`include "flow_map.vh"
module flow_assertions (
    input logic        clock, sys_rst, op_valid, op_ready,
    input logic [4:0]  op_code,
    input logic [15:0] pc_in, z_pointer, push_data, pc_out, stack_data,
    input logic [11:0] rel_offset,
    input logic [2:0]  flag_index,
    input logic [7:0]  flags_in, flags_out, reg_a, reg_b,
    input logic        stack_push, stack_pop, pc_load, flags_we, done
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic take, br, hit;
    assign take = op_valid & op_ready;
    assign br = take & (op_code == `OP_BR_IDX_SET | op_code == `OP_BR_IDX_CLR);
    // index 4 is the signed test, not the stored bit
    assign hit = (flag_index == 3'h4 ? flags_in[2] ^ flags_in[3] : flags_in[flag_index])
                 ^ (op_code == `OP_BR_IDX_CLR);
    sequence s_ret;
        take && (op_code == `OP_RET_SUB || op_code == `OP_RET_INT);
    endsequence
    sequence s_reload;
        pc_load && done && pc_out == stack_data;
    endsequence
    chk_rel_call: assert property (
        take && op_code == `OP_RELATIVE_SUBROUTINE_CALL_REL |=> stack_push && push_data == $past(pc_in) + 16'h0001 ##2 done)
        else $error("relative call push or cost wrong");
    chk_ind_call: assert property (
        take && op_code == `OP_CALL_IND |=> pc_load && pc_out == $past(z_pointer) ##2 done)
        else $error("indirect call target or cost wrong");
    chk_abs_call: assert property (
        take && op_code == `OP_CALL_ABS |=> stack_push ##3 done)
        else $error("absolute call cost wrong");
    chk_ret_reload: assert property (s_ret |=> stack_pop ##3 s_reload)
        else $error("return reload wrong");
    chk_interrupt_return_ien: assert property (
        take && op_code == `OP_RET_INT |-> ##4 flags_we && flags_out == ($past(flags_in, 4) | 8'h80))
        else $error("interrupt return flags wrong");
    chk_ret_quiet: assert property (take && op_code == `OP_RET_SUB |=> !flags_we [*4])
        else $error("return wrote flags");
    chk_cmp_one: assert property (
        take && op_code inside {`OP_CMP_REG, `OP_CMP_CARRY, `OP_CMP_IMM} |=> flags_we && done)
        else $error("compare not one cycle");
    chk_cmp_zero: assert property (
        take && op_code == `OP_CMP_REG |=> flags_out[1] == ($past(reg_a) == $past(reg_b)))
        else $error("compare zero flag wrong");
    chk_br_taken: assert property (br && hit |=> pc_load
        && pc_out == $past(pc_in) + {{4{$past(rel_offset[11])}}, $past(rel_offset)} + 16'h0001 ##1 done)
        else $error("taken branch wrong");
    chk_br_miss: assert property (br && !hit |=> done && !pc_load)
        else $error("untaken branch wrong");
endmodule
bind branch_call_skip_unit flow_assertions chk_u (.*);

/* File: bench/branch_call_skip_unit_bench.sv */
/* self-checking bench for the program-flow unit.
   assumes the stack model as partner; outputs settled 2 ns after the edge. */
`timescale 1ns/1ps
`include "flow_map.vh"
module branch_call_skip_unit_bench;
    logic        clock, sys_rst, op_valid, next_is_two_word, op_ready;
    logic [4:0]  op_code;
    logic [15:0] pc_in, abs_target, z_pointer, stack_data, push_data, pc_out;
    logic [11:0] rel_offset;
    logic [2:0]  flag_index, bit_select;
    logic [7:0]  reg_a, reg_b, imm_value, io_value, flags_in, flags_out, seen_flags;
    logic        stack_push, stack_pop, pc_load, flags_we, done, seen_we;
    logic [7:0]  pa [3] = '{8'h3C, 8'h80, 8'h10};
    logic [7:0]  pb [3] = '{8'h3C, 8'h01, 8'h0F};
    logic [7:0]  pf [3] = '{8'h3C, 8'hC3, 8'h36};
    int          mismatches, compares;
    branch_call_skip_unit dut_u (.*);
    flow_stack_model partner_u (.*);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task check(input string what, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish;
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // entered 2 ns after an edge, so ops follow each other back to back
    task run(input logic [4:0] op, input logic [2:0] cyc, input logic ld, input logic [15:0] pc);
        logic [2:0]  n;
        logic        got;
        logic [15:0] gpc;
        n = 3'h0;
        got = 1'b0;
        seen_we = 1'b0;
        check("ready", op_ready, 1'b1);
        op_valid = 1'b1;
        op_code = op;
        @(posedge clock);
        #2;
        while (1) begin
            n++;
            got |= pc_load;
            seen_we |= flags_we;
            if (pc_load) gpc = pc_out;
            if (flags_we) seen_flags = flags_out;
            // valid stays up after a one-cycle op, so back-to-back calls never pulse it
            if (done === 1'b1) break;
            op_valid = 1'b0;
            check("busy ready", op_ready, 1'b0);
            if (n == 3'h6) begin
                mismatches++;
                tally_and_finish();
            end
            @(posedge clock);
            #2;
        end
        check("cycles", n, cyc);
        check("pc load", got, ld);
        if (ld) check("pc", gpc, pc);
    endtask
    function logic [7:0] cmp_flags(input logic [7:0] a, b, f, input logic cin, keepz);
        logic [8:0] w;
        logic [4:0] lo;
        logic       v;
        // borrows taken from wider subtractions, not from bit equations
        w = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        v = (a[7] != b[7]) && (w[7] != a[7]);
        return {f[7:6], lo[4], w[7] ^ v, v, w[7], (w[7:0] == 8'h00) & (~keepz | f[1]), w[8]};
    endfunction
    task calls_returns;
        flags_in = 8'h2A;
        pc_in = 16'h0200;
        rel_offset = 12'h800;
        run(`OP_RELATIVE_SUBROUTINE_CALL_REL, 3'h3, 1'b1, 16'hFA01);
        check("push", push_data, 16'h0201);
        pc_in = 16'h0210;
        z_pointer = 16'h1234;
        run(`OP_CALL_IND, 3'h3, 1'b1, 16'h1234);
        pc_in = 16'h0300;
        abs_target = 16'h4567;
        run(`OP_CALL_ABS, 3'h4, 1'b1, 16'h4567);
        check("push", push_data, 16'h0302);
        run(`OP_RET_SUB, 3'h4, 1'b1, 16'h0302);
        run(`OP_RET_INT, 3'h4, 1'b1, 16'h0211);
        check("interrupt_return flags", seen_flags, 8'hAA);
        run(`OP_RET_SUB, 3'h4, 1'b1, 16'h0201);
        check("ret flags", seen_we, 1'b0);
    endtask
    task compare_ops;
        logic [4:0] op;
        flags_in = 8'h43;
        for (int i = 0; i < 9; i++) begin
            op = `OP_CMP_REG + 5'(i / 3);
            reg_a = pa[i % 3];
            imm_value = pb[i % 3];
            // immediate form must ignore the register operand
            reg_b = (op == `OP_CMP_IMM) ? ~pb[i % 3] : pb[i % 3];
            run(op, 3'h1, 1'b0, 16'h0000);
            check("cmp we", seen_we, 1'b1);
            check("cmp flags", seen_flags,
                  cmp_flags(pa[i % 3], pb[i % 3], flags_in, op == `OP_CMP_CARRY, op == `OP_CMP_CARRY));
        end
    endtask
    task skip_ops;
        logic skip;
        pc_in = 16'h0400;
        for (int i = 0; i < 34; i++) begin
            reg_a = i < 32 ? 8'hA5 : 8'h33;
            reg_b = i == 32 ? 8'h33 : 8'h34;
            io_value = 8'h5A;
            bit_select = 3'(i / 4);
            next_is_two_word = i[2] ^ i[3] ^ i[5];
            skip = i < 32 ? (i[1] ? io_value[bit_select] : reg_a[bit_select]) == i[0] : i == 32;
            run(i < 32 ? `OP_SKIP_RB_CLR + 5'(i % 4) : `OP_CMP_SKIP_EQ,
                skip ? (next_is_two_word ? 3'h3 : 3'h2) : 3'h1, skip, pc_in + 16'h0002 + next_is_two_word);
            check("skip flags", seen_we, 1'b0);
        end
    endtask
    task branch_ops;
        logic pol, hit;
        pc_in = 16'h0100;
        for (int i = 0; i < 48; i++) begin
            flags_in = pf[i % 3];
            flag_index = 3'(i / 6);
            rel_offset = i[0] ? 12'hFFE : 12'h123;
            pol = (i % 6) >= 3;
            hit = (flag_index == 3'h4 ? flags_in[2] ^ flags_in[3] : flags_in[flag_index]) ^ pol;
            run(pol ? `OP_BR_IDX_CLR : `OP_BR_IDX_SET, hit ? 3'h2 : 3'h1, hit,
                pc_in + {{4{rel_offset[11]}}, rel_offset} + 16'h0001);
        end
    endtask
    initial begin
        mismatches = 0;
        compares = 0;
        sys_rst = 1'b1;
        op_valid = 1'b0;
        op_code = `OP_NONE;
        {pc_in, abs_target, z_pointer, rel_offset, flag_index, reg_a, reg_b} = '0;
        {imm_value, bit_select, io_value, flags_in, next_is_two_word} = '0;
        repeat (16) @(posedge clock);
        #2;
        sys_rst = 1'b0;
        @(posedge clock);
        #2;
        calls_returns();
        compare_ops();
        skip_ops();
        branch_ops();
        tally_and_finish();
    end
endmodule
